// File: hdl/ppaf_pkg.sv
package ppaf_pkg;

  // Special-function register addresses
  localparam logic [7:0] PPAF_SFR_PORT_ONE    = 8'h90;
  localparam logic [7:0] PPAF_SFR_DRIVE_CFG   = 8'h9F;
  localparam logic [7:0] PPAF_SFR_ALT_FN      = 8'hAB;
  localparam logic [7:0] PPAF_SFR_PORT_THREE  = 8'hB0;
  localparam logic [7:0] PPAF_SFR_CONTROL     = 8'hD8;

  // External data space addresses of the output-only ports
  localparam logic [15:0] PPAF_XD_OUT_A       = 16'hFFF0;
  localparam logic [15:0] PPAF_XD_OUT_B       = 16'hFFF1;

  // Reset values
  localparam logic [7:0] PPAF_PORT_RST        = 8'hFF;
  localparam logic [7:0] PPAF_OUT_RST         = 8'h00;
  localparam logic [7:0] PPAF_CFG_RST         = 8'h00;
  localparam logic [7:0] PPAF_ALT_RST         = 8'h00;
  localparam logic [5:0] PPAF_CTL_RST         = 6'h3F;

  // Alternative-function register fields; bit 7 is reserved
  localparam logic [7:0] PPAF_ALT_WMASK       = 8'h7F;
  localparam int         PPAF_ALT_MODE_LO     = 5;
  localparam int         PPAF_ALT_CTL5_PP     = 4;
  localparam int         PPAF_ALT_GPC_ON      = 3;
  localparam int         PPAF_ALT_GPC_SRC     = 2;
  localparam int         PPAF_ALT_LE_ON       = 1;
  localparam int         PPAF_ALT_LE_EARLY    = 0;

  // Drive-configuration register fields
  localparam int         PPAF_CFG_WR          = 7;
  localparam int         PPAF_CFG_RD          = 6;
  localparam int         PPAF_CFG_EAM         = 5;

  // Mode of the four shared port-three pins, in field order
  typedef enum logic [1:0] {
    PPAF_MODE_GPIO,
    PPAF_MODE_TONE,
    PPAF_MODE_SLAVE,
    PPAF_MODE_MASTER
  } ppaf_mode_t;

  // Pin drive: value and output enable per bit
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } ppaf_drv_t;

endpackage

// File: hdl/ppaf_top.sv
// Operation
// - Both weak-pull-up ports reset to all ones
// - Sixteen push-pull outputs reset to zero
// - Alternative outputs ANDed with port latch bit
// - Port one bits 7,6 optional open-drain two-wire
// - Ten inputs remain, seven interrupt capable
// - Port three: timers on 5,4; interrupts 3,2
// - Port three bits 6,7 carry no strobes
// - Alt bits 6,5 select four-pin mode
// - Tone and serial-bus pin directions per mode
// - Slave mode: quasi pin 0, pull-ups 1,6,7
// - Drive bits: zero open-drain, one push-pull
// - Control bit 5 drive from alt bit 4
// - Drive bit 5 enables enhanced addressing
// - Alt bits: clock out, latch strobe, reserved
// - Bit-addressable SFR ports; output ports in xdata
// - Control port carries flash and display signals
module ppaf_top
  import ppaf_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Special-function register byte access
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  // Special-function register bit access
  input  wire logic [7:0] sfr_bit_addr,
  input  wire logic       sfr_bit_wr,
  input  wire logic       sfr_bit_wdata,
  input  wire logic       sfr_bit_rd,
  output logic            sfr_bit_rdata,
  // External data space access
  input  wire logic [15:0] xd_addr,
  input  wire logic        xd_wr,
  input  wire logic [7:0]  xd_wdata,
  input  wire logic        xd_rd,
  output logic      [7:0]  xd_rdata,
  // Port pins
  input  wire logic [7:0] port_one_in,
  output ppaf_drv_t       port_one_drv,
  input  wire logic [7:0] port_three_in,
  output ppaf_drv_t       port_three_drv,
  input  wire logic [5:0] control_port_in,
  output ppaf_drv_t       control_port_drv,
  output logic      [7:0] output_port_a,
  output logic      [7:0] output_port_b,
  // Alternative outputs from peripherals, idle high
  input  wire logic       i2c_enable,
  input  wire logic       i2c_sda_out,
  input  wire logic       i2c_scl_out,
  input  wire logic       tone_tx_bit0,
  input  wire logic       tone_tx_bit1,
  input  wire logic       tone_tx_bit2,
  input  wire logic       serial_data_out,
  input  wire logic       serial_bit_clock_out,
  input  wire logic       frame_sync_out,
  input  wire logic       general_clock_out,
  input  wire logic       latch_strobe,
  input  wire logic       control_alt_out_a,
  input  wire logic       control_alt_out_b,
  // Alternative inputs to peripherals, synchronised
  output logic            i2c_sda_in,
  output logic            i2c_scl_in,
  output logic            tone_rx_in,
  output logic            serial_data_in,
  output logic            serial_bit_clock,
  output logic            frame_sync,
  output logic            timer0_input,
  output logic            timer1_input,
  output logic            ext_irq_zero,
  output logic            ext_irq_one,
  output logic      [4:0] ext_irq_two,
  output logic            control_alt_in,
  // Configuration towards other blocks
  output ppaf_mode_t      modem_mode,
  output logic            general_clock_source,
  output logic            latch_strobe_early,
  output logic            enhanced_addr_select,
  output logic            wr_strobe_push_pull,
  output logic            rd_strobe_push_pull
);

  logic [7:0]  port_one_q;
  logic [7:0]  port_three_q;
  logic [5:0]  control_port_q;
  logic [7:0]  drive_config_reg_q;
  logic [7:0]  alt_function_reg_q;
  logic [21:0] pin_meta_q;
  logic [21:0] pin_sync_q;
  logic [7:0]  p1_sync;
  logic [7:0]  p3_sync;
  logic [5:0]  p4_sync;
  logic [7:0]  p1_val;
  logic [7:0]  p3_val;
  logic [5:0]  p4_val;
  logic [7:0]  rd_mux;

  // Byte write, else bit write, onto an SFR latch
  function automatic logic [7:0] ppaf_next(input logic [7:0] cur, input logic [7:0] base, input logic bwr,
                                           input logic [7:0] baddr, input logic [7:0] bdata, input logic bitwr,
                                           input logic [7:0] bitaddr, input logic bitdata);
    logic [7:0] n;
    n = cur;
    if (bwr && baddr == base)
      n = bdata;
    else if (bitwr && bitaddr[7:3] == base[7:3])
      n[bitaddr[2:0]] = bitdata;
    return n;
  endfunction

  // Port one and port three latches, bit addressable
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      port_one_q   <= PPAF_PORT_RST;
      port_three_q <= PPAF_PORT_RST;
    end
    else
    begin
      port_one_q   <= ppaf_next(port_one_q, PPAF_SFR_PORT_ONE, sfr_wr, sfr_addr, sfr_wdata,
                                sfr_bit_wr, sfr_bit_addr, sfr_bit_wdata);
      port_three_q <= ppaf_next(port_three_q, PPAF_SFR_PORT_THREE, sfr_wr, sfr_addr, sfr_wdata,
                                sfr_bit_wr, sfr_bit_addr, sfr_bit_wdata);
    end
  end

  // Control port latch, six bits, upper two read as zero
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      control_port_q <= PPAF_CTL_RST;
    else
      control_port_q <= 6'(ppaf_next({2'b00, control_port_q}, PPAF_SFR_CONTROL, sfr_wr, sfr_addr,
                                     sfr_wdata, sfr_bit_wr, sfr_bit_addr, sfr_bit_wdata));
  end

  // Drive configuration and alternative-function registers, byte access only
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      drive_config_reg_q <= PPAF_CFG_RST;
      alt_function_reg_q <= PPAF_ALT_RST;
    end
    else if (sfr_wr)
    begin
      if (sfr_addr == PPAF_SFR_DRIVE_CFG)
        drive_config_reg_q <= sfr_wdata;
      if (sfr_addr == PPAF_SFR_ALT_FN)
        alt_function_reg_q <= sfr_wdata & PPAF_ALT_WMASK;
    end
  end

  // Output-only ports live in external data space; bit access never reaches them
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      output_port_a <= PPAF_OUT_RST;
      output_port_b <= PPAF_OUT_RST;
    end
    else if (xd_wr)
    begin
      if (xd_addr == PPAF_XD_OUT_A)
        output_port_a <= xd_wdata;
      if (xd_addr == PPAF_XD_OUT_B)
        output_port_b <= xd_wdata;
    end
  end

  // Two-stage synchroniser on every pin input; first stage feeds only the second
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pin_meta_q <= '1;
      pin_sync_q <= '1;
    end
    else
    begin
      pin_meta_q <= {control_port_in, port_three_in, port_one_in};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign p1_sync = pin_sync_q[7:0];
  assign p3_sync = pin_sync_q[15:8];
  assign p4_sync = pin_sync_q[21:16];

  // Read mux: ports return pin level, not latch, as a quasi pin must
  always_comb
  begin
    case (sfr_addr)
      PPAF_SFR_PORT_ONE:   rd_mux = p1_sync;
      PPAF_SFR_PORT_THREE: rd_mux = p3_sync;
      PPAF_SFR_CONTROL:    rd_mux = {2'b00, p4_sync};
      PPAF_SFR_DRIVE_CFG:  rd_mux = drive_config_reg_q;
      PPAF_SFR_ALT_FN:     rd_mux = alt_function_reg_q;
      default:             rd_mux = 8'h00;
    endcase
  end

  // Registered read answers, one cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      sfr_rdata     <= 8'h00;
      sfr_bit_rdata <= 1'b0;
      xd_rdata      <= 8'h00;
    end
    else
    begin
      if (sfr_rd)
        sfr_rdata <= rd_mux;
      if (sfr_bit_rd)
      begin
        case (sfr_bit_addr[7:3])
          PPAF_SFR_PORT_ONE[7:3]:   sfr_bit_rdata <= p1_sync[sfr_bit_addr[2:0]];
          PPAF_SFR_PORT_THREE[7:3]: sfr_bit_rdata <= p3_sync[sfr_bit_addr[2:0]];
          PPAF_SFR_CONTROL[7:3]:    sfr_bit_rdata <= (sfr_bit_addr[2:1] == 2'b11) ? 1'b0 : p4_sync[sfr_bit_addr[2:0]];
          default:                  sfr_bit_rdata <= 1'b0;
        endcase
      end
      if (xd_rd)
        xd_rdata <= (xd_addr == PPAF_XD_OUT_A) ? output_port_a : (xd_addr == PPAF_XD_OUT_B) ? output_port_b : 8'h00;
    end
  end

  assign modem_mode = ppaf_mode_t'(alt_function_reg_q[PPAF_ALT_MODE_LO +: 2]);

  // Pin values: latch ANDed with the alternative output; data on bit 7, clock on bit 6
  assign p1_val = port_one_q & {i2c_enable ? i2c_sda_out : 1'b1,
                                i2c_enable ? i2c_scl_out : 1'b1, 6'h3F};

  // Shared port-three pins pick their alternative source by mode
  always_comb
  begin
    case (modem_mode)
      PPAF_MODE_TONE:
        p3_val = port_three_q & {1'b1, tone_tx_bit2, 4'hF, tone_tx_bit1, tone_tx_bit0};
      PPAF_MODE_MASTER:
        p3_val = port_three_q & {1'b1, frame_sync_out, 4'hF, serial_bit_clock_out,
                                 serial_data_out};
      PPAF_MODE_SLAVE:
        p3_val = port_three_q & {7'h7F, serial_data_out};
      default:
        p3_val = port_three_q;
    endcase
  end

  // Port one: quasi pins pull low only; high comes from the weak pull-up
  assign port_one_drv.o  = 8'h00;
  assign port_one_drv.oe = ~p1_val;

  // Port three direction per mode; forced-input pins ignore a low latch, hence the ordering
  always_comb
  begin
    port_three_drv.o  = 8'h00;
    port_three_drv.oe = ~p3_val;
    case (modem_mode)
      PPAF_MODE_TONE:
      begin
        port_three_drv.o     = p3_val & 8'h43;
        port_three_drv.oe    = 8'h43 | ~p3_val;
        port_three_drv.oe[7] = 1'b0;
      end
      PPAF_MODE_MASTER:
      begin
        port_three_drv.o     = p3_val & 8'h42;
        port_three_drv.oe    = 8'h42 | ~p3_val;
        port_three_drv.oe[7] = 1'b0;
      end
      PPAF_MODE_SLAVE:
      begin
        port_three_drv.oe[1] = 1'b0;
        port_three_drv.oe[6] = 1'b0;
        port_three_drv.oe[7] = 1'b0;
      end
      default:
        port_three_drv.o = 8'h00;
    endcase
  end

  // Control port alternative outputs; clock and strobe gated by their enables
  assign p4_val = control_port_q & {alt_function_reg_q[PPAF_ALT_GPC_ON] ? general_clock_out : 1'b1,
                                    2'b11, control_alt_out_b, control_alt_out_a,
                                    alt_function_reg_q[PPAF_ALT_LE_ON] ? latch_strobe : 1'b1};

  // Control port drive per bit; bit 5 takes its mode from the alt register
  for (genvar i = 0; i < 6; i++)
  begin : g_ctl
    logic pp;
    assign pp = (i == 5) ? alt_function_reg_q[PPAF_ALT_CTL5_PP] : drive_config_reg_q[i];
    assign control_port_drv.o[i]  = pp & p4_val[i];
    assign control_port_drv.oe[i] = pp | ~p4_val[i];
  end
  assign {control_port_drv.o[7:6], control_port_drv.oe[7:6]} = 4'h0;

  // Alternative inputs; bits 6,7 of port three carry no strobes
  assign i2c_sda_in       = p1_sync[7];
  assign i2c_scl_in       = p1_sync[6];
  assign ext_irq_two      = p1_sync[4:0];
  assign ext_irq_zero     = p3_sync[2];
  assign ext_irq_one      = p3_sync[3];
  assign timer0_input     = p3_sync[4];
  assign timer1_input     = p3_sync[5];
  assign tone_rx_in       = p3_sync[7];
  assign serial_data_in   = p3_sync[7];
  assign serial_bit_clock = p3_sync[1];
  assign frame_sync       = p3_sync[6];
  assign control_alt_in   = p4_sync[4];

  // Configuration handed to neighbouring blocks
  assign general_clock_source = alt_function_reg_q[PPAF_ALT_GPC_SRC];
  assign latch_strobe_early   = alt_function_reg_q[PPAF_ALT_LE_EARLY];
  assign enhanced_addr_select = drive_config_reg_q[PPAF_CFG_EAM];
  assign wr_strobe_push_pull  = drive_config_reg_q[PPAF_CFG_WR];
  assign rd_strobe_push_pull  = drive_config_reg_q[PPAF_CFG_RD];

  // Checks
  a_port_reset_ones: assert property (@(posedge sys_clk)
    !$past(reset_n) && reset_n |-> port_one_q == 8'hFF && port_three_q == 8'hFF)
    else $error("weak pull-up ports not all ones after reset");
  a_outport_reset_zero: assert property (@(posedge sys_clk)
    !$past(reset_n) && reset_n |-> output_port_a == 8'h00 && output_port_b == 8'h00 && drive_config_reg_q == 8'h00)
    else $error("output ports or drive config not zero after reset");
  a_p1_and_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    i2c_enable && !port_one_q[7] |-> port_one_drv.oe[7])
    else $error("low latch did not force pin low");
  a_p1_byte_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sfr_wr && sfr_addr == PPAF_SFR_PORT_ONE |=> port_one_q == $past(sfr_wdata))
    else $error("port one byte write lost");
  a_p3_bit_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sfr_bit_wr && !sfr_wr && sfr_bit_addr[7:3] == PPAF_SFR_PORT_THREE[7:3]
    |=> port_three_q[$past(sfr_bit_addr[2:0])] == $past(sfr_bit_wdata))
    else $error("port three bit write lost");
  a_outport_no_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sfr_bit_wr && !xd_wr |=> $stable(output_port_a) && $stable(output_port_b))
    else $error("output port changed by bit access");
  a_tone_pin_dirs: assert property (@(posedge sys_clk) disable iff (!reset_n)
    modem_mode == PPAF_MODE_TONE |-> port_three_drv.oe[1:0] == 2'b11 && port_three_drv.oe[7:6] == 2'b01)
    else $error("tone mode pin directions wrong");
  a_slave_inputs: assert property (@(posedge sys_clk) disable iff (!reset_n)
    modem_mode == PPAF_MODE_SLAVE |-> {port_three_drv.oe[7:6], port_three_drv.oe[1], port_three_drv.o} == 11'h000)
    else $error("slave mode drives clock or sync");
  a_gpio_quasi: assert property (@(posedge sys_clk) disable iff (!reset_n)
    modem_mode == PPAF_MODE_GPIO |-> port_three_drv.oe == ~port_three_q)
    else $error("plain mode port three not quasi");
  a_ctl5_drive: assert property (@(posedge sys_clk) disable iff (!reset_n)
    alt_function_reg_q[4] |-> control_port_drv.oe[5])
    else $error("control bit 5 not push-pull");
  a_pin_readback: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sfr_rd && sfr_addr == PPAF_SFR_PORT_ONE && $stable(port_one_in) && $past(port_one_in, 2) == port_one_in
    |=> sfr_rdata == $past(port_one_in)) else $error("port read did not return pin level");

  c_tone_mode: cover property (@(posedge sys_clk) modem_mode == PPAF_MODE_TONE);
  c_master_mode: cover property (@(posedge sys_clk) modem_mode == PPAF_MODE_MASTER);
  c_bit_write: cover property (@(posedge sys_clk) sfr_bit_wr && sfr_bit_addr[7:3] == PPAF_SFR_PORT_THREE[7:3]);
  c_p1_read: cover property (@(posedge sys_clk) sfr_rd && sfr_addr == PPAF_SFR_PORT_ONE);

endmodule // ppaf_top

// File: test/ppaf_board.sv
// Board side of the port pins: pull-ups and parts that pull lines low
module ppaf_board
  import ppaf_pkg::*;
(
  // Drive from the device
  input  wire ppaf_drv_t  one_drv,
  input  wire ppaf_drv_t  three_drv,
  input  wire ppaf_drv_t  ctl_drv,
  // Board parts pulling a line low, one bit per pin
  input  wire logic [7:0] one_low,
  input  wire logic [7:0] three_low,
  input  wire logic [5:0] ctl_low,
  // Resolved pin levels
  output logic      [7:0] one_pin,
  output logic      [7:0] three_pin,
  output logic      [5:0] ctl_pin
);

  timeunit 1ns;
  timeprecision 1ns;

  // Weak pull-up holds an undriven pin high unless a part pulls it down
  assign one_pin   = (one_drv.oe & one_drv.o) | (~one_drv.oe & ~one_low);
  assign three_pin = (three_drv.oe & three_drv.o) | (~three_drv.oe & ~three_low);
  // Open-drain control lines rely on board pull-ups when released
  assign ctl_pin   = (ctl_drv.oe[5:0] & ctl_drv.o[5:0]) | (~ctl_drv.oe[5:0] & ~ctl_low);

endmodule // ppaf_board

// File: test/ppaf_tb_top.sv
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end

module ppaf_tb_top
  import ppaf_pkg::*;
;

  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk, reset_n, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_wdata, sfr_bit_rd, sfr_bit_rdata;
  logic        xd_wr, xd_rd, i2c_enable, i2c_sda_out, i2c_scl_out, tone_tx_bit0, tone_tx_bit1, tone_tx_bit2;
  logic        serial_data_out, serial_bit_clock_out, frame_sync_out, general_clock_out, latch_strobe;
  logic        control_alt_out_a, control_alt_out_b, i2c_sda_in, i2c_scl_in, tone_rx_in, serial_data_in;
  logic        serial_bit_clock, frame_sync, timer0_input, timer1_input, ext_irq_zero, ext_irq_one;
  logic        control_alt_in, general_clock_source, latch_strobe_early, enhanced_addr_select;
  logic        wr_strobe_push_pull, rd_strobe_push_pull;
  logic [4:0]  ext_irq_two;
  logic [5:0]  ctl_pin, ctl_low;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, sfr_bit_addr, xd_wdata, xd_rdata;
  logic [7:0]  output_port_a, output_port_b, one_pin, three_pin, one_low, three_low;
  logic [15:0] xd_addr;
  ppaf_drv_t   port_one_drv, port_three_drv, control_port_drv;
  ppaf_mode_t  modem_mode;
  int          n_errors, total_checks;
  // Expected port-three drive per mode, all latches one, serial data out low
  logic [7:0]  exp_o [4] = '{8'h00, 8'h43, 8'h00, 8'h42};
  logic [7:0]  exp_oe [4] = '{8'h00, 8'h43, 8'h01, 8'h43};

  ppaf_top ppaf_top_i (
    .sys_clk, .reset_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
    .sfr_bit_addr, .sfr_bit_wr, .sfr_bit_wdata, .sfr_bit_rd, .sfr_bit_rdata,
    .xd_addr, .xd_wr, .xd_wdata, .xd_rd, .xd_rdata,
    .port_one_in(one_pin), .port_one_drv, .port_three_in(three_pin), .port_three_drv,
    .control_port_in(ctl_pin), .control_port_drv, .output_port_a, .output_port_b,
    .i2c_enable, .i2c_sda_out, .i2c_scl_out, .tone_tx_bit0, .tone_tx_bit1, .tone_tx_bit2,
    .serial_data_out, .serial_bit_clock_out, .frame_sync_out, .general_clock_out, .latch_strobe,
    .control_alt_out_a, .control_alt_out_b, .i2c_sda_in, .i2c_scl_in, .tone_rx_in, .serial_data_in,
    .serial_bit_clock, .frame_sync, .timer0_input, .timer1_input, .ext_irq_zero, .ext_irq_one,
    .ext_irq_two, .control_alt_in, .modem_mode, .general_clock_source, .latch_strobe_early,
    .enhanced_addr_select, .wr_strobe_push_pull, .rd_strobe_push_pull
  );

  ppaf_board ppaf_board_i (
    .one_drv(port_one_drv), .three_drv(port_three_drv), .ctl_drv(control_port_drv),
    .one_low, .three_low, .ctl_low, .one_pin, .three_pin, .ctl_pin
  );

  // Free-running system clock, 40 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // One access: k 0 byte SFR, 1 bit SFR, 2 external data; w high writes
  task automatic acc(input int k, input bit w, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    sfr_addr = a[7:0];
    sfr_bit_addr = a[7:0];
    xd_addr = a;
    sfr_wdata = d;
    xd_wdata = d;
    sfr_bit_wdata = d[0];
    {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_rd, xd_wr, xd_rd} = {k == 0 && w, k == 0 && !w,
      k == 1 && w, k == 1 && !w, k == 2 && w, k == 2 && !w};
    @(posedge sys_clk);
    #1;
    {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_rd, xd_wr, xd_rd} = 6'h00;
    @(posedge sys_clk);
    #1;
  endtask

  // Wait cycles, landing just after an edge; three cover the pin synchronisers
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog, far beyond the hundred or so cycles the sequence needs
  initial
  begin
    #100000;
    n_errors++;
    give_verdict;
  end

  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_rd, xd_wr, xd_rd, sfr_bit_wdata, i2c_enable} = 8'h00;
    {sfr_addr, sfr_wdata, sfr_bit_addr, xd_wdata, xd_addr} = 48'h0;
    {one_low, three_low, ctl_low} = 22'h0;
    // Alternative outputs idle high so the AND gating passes the latch
    {i2c_sda_out, i2c_scl_out, tone_tx_bit0, tone_tx_bit1, tone_tx_bit2, serial_data_out} = 6'h3F;
    {serial_bit_clock_out, frame_sync_out, general_clock_out, latch_strobe} = 4'hF;
    {control_alt_out_a, control_alt_out_b} = 2'h3;
    n_errors = 0;
    total_checks = 0;
    repeat (6) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    wt(1);
    // Reset state
    `CHK("p1_oe", 8'h00, port_one_drv.oe)
    `CHK("p3_oe", 8'h00, port_three_drv.oe)
    `CHK("out_a", 8'h00, output_port_a)
    `CHK("out_b", 8'h00, output_port_b)
    `CHK("mode", PPAF_MODE_GPIO, modem_mode)
    `CHK("ctl_oe", 8'h00, control_port_drv.oe)
    acc(0, 0, 16'h009F, 8'h00);
    `CHK("cfg", 8'h00, sfr_rdata)
    acc(0, 0, 16'h00AB, 8'h00);
    `CHK("alt", 8'h00, sfr_rdata)
    acc(0, 0, 16'h0090, 8'h00);
    `CHK("p1_rd", 8'hFF, sfr_rdata)
    // Output-only ports in external data space, plus an unmapped place
    acc(2, 1, 16'hFFF0, 8'h3C);
    acc(2, 1, 16'hFFF1, 8'hC3);
    `CHK("out_a", 8'h3C, output_port_a)
    `CHK("out_b", 8'hC3, output_port_b)
    acc(2, 0, 16'hFFF1, 8'h00);
    `CHK("xd_rd", 8'hC3, xd_rdata)
    acc(2, 0, 16'hFFF2, 8'h00);
    `CHK("xd_none", 8'h00, xd_rdata)
    // Port one latch zeros pull low, ones read back the pin
    acc(0, 1, 16'h0090, 8'h55);
    `CHK("p1_oe", 8'hAA, port_one_drv.oe)
    wt(3);
    acc(0, 0, 16'h0090, 8'h00);
    `CHK("p1_rd", 8'h55, sfr_rdata)
    acc(0, 1, 16'h0090, 8'hFF);
    one_low = 8'h0F;
    wt(3);
    acc(0, 0, 16'h0090, 8'h00);
    `CHK("p1_in", 8'hF0, sfr_rdata)
    `CHK("irq_two", 5'h10, ext_irq_two)
    one_low = 8'h00;
    // Two-wire outputs gated with the latch
    i2c_enable = 1'b1;
    i2c_sda_out = 1'b0;
    wt(1);
    `CHK("i2c_oe", 8'h80, port_one_drv.oe)
    i2c_sda_out = 1'b1;
    acc(0, 1, 16'h0090, 8'h7F);
    `CHK("i2c_gate", 8'h80, port_one_drv.oe)
    wt(3);
    `CHK("sda_in", 1'b0, i2c_sda_in)
    `CHK("scl_in", 1'b1, i2c_scl_in)
    acc(0, 1, 16'h0090, 8'hFF);
    i2c_enable = 1'b0;
    // Port three inputs for timers and interrupts
    three_low = 8'hFE;
    wt(3);
    `CHK("p3_in", 4'h0, {timer1_input, timer0_input, ext_irq_one, ext_irq_zero})
    `CHK("p3_alt_in", 4'h0, {tone_rx_in, serial_data_in, frame_sync, serial_bit_clock})
    three_low = 8'h00;
    // Bit access: port three reacts, the alternative-function register does not
    acc(1, 1, 16'h00B3, 8'h00);
    `CHK("bit_wr", 8'h08, port_three_drv.oe)
    wt(3);
    acc(1, 0, 16'h00B3, 8'h00);
    `CHK("bit_rd3", 1'b0, sfr_bit_rdata)
    acc(1, 0, 16'h00B4, 8'h00);
    `CHK("bit_rd4", 1'b1, sfr_bit_rdata)
    acc(1, 1, 16'h00AB, 8'h01);
    acc(0, 0, 16'h00AB, 8'h00);
    `CHK("alt_nobit", 8'h00, sfr_rdata)
    acc(0, 1, 16'h00B0, 8'hFF);
    // Every four-pin mode with serial data out low
    serial_data_out = 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      acc(0, 1, 16'h00AB, {1'b0, 2'(m), 5'h00});
      `CHK("mode", 2'(m), modem_mode)
      `CHK("p3_o", exp_o[m], port_three_drv.o)
      `CHK("p3_oe", exp_oe[m], port_three_drv.oe)
    end
    serial_data_out = 1'b1;
    // Reserved bit reads zero; clock and strobe selects reach their outputs
    acc(0, 1, 16'h00AB, 8'hFF);
    acc(0, 0, 16'h00AB, 8'h00);
    `CHK("alt_rsv", 8'h7F, sfr_rdata)
    `CHK("alt_sel", 2'h3, {general_clock_source, latch_strobe_early})
    acc(0, 1, 16'h00AB, 8'h00);
    // Drive configuration of the control port
    acc(0, 1, 16'h009F, 8'hE5);
    acc(0, 0, 16'h009F, 8'h00);
    `CHK("cfg", 8'hE5, sfr_rdata)
    `CHK("cfg_out", 3'h7, {wr_strobe_push_pull, rd_strobe_push_pull, enhanced_addr_select})
    `CHK("ctl_o", 8'h05, control_port_drv.o)
    `CHK("ctl_oe", 8'h05, control_port_drv.oe)
    acc(0, 1, 16'h00AB, 8'h10);
    `CHK("ctl5_oe", 8'h25, control_port_drv.oe)
    control_alt_out_a = 1'b0;
    wt(1);
    `CHK("ctl_alt_oe", 8'h27, control_port_drv.oe)
    `CHK("ctl_alt_o", 8'h25, control_port_drv.o)
    control_alt_out_a = 1'b1;
    ctl_low = 6'h10;
    wt(3);
    `CHK("ctl_in", 1'b0, control_alt_in)
    acc(0, 0, 16'h00D8, 8'h00);
    `CHK("ctl_rd", 8'h2F, sfr_rdata)
    // Reset in mid-run brings latches, outputs and drive configuration back
    acc(0, 1, 16'h00B0, 8'h00);
    reset_n = 1'b0;
    wt(2);
    reset_n = 1'b1;
    wt(1);
    `CHK("rst_p3_oe", 8'h00, port_three_drv.oe)
    `CHK("rst_out_a", 8'h00, output_port_a)
    `CHK("rst_ctl_oe", 8'h00, control_port_drv.oe)
    give_verdict;
  end

endmodule // ppaf_tb_top
